// file: bpc_top.sv
/*
 * Digital control core of a boost converter: single-line pulse decoder,
 * 6-bit level code, softstart current-limit sequencer, PFM switch timer
 * and an AXI4-Lite register slave.
 * Assumes comparators, lockout and thermal flags arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
module bpc_top
    import bpc_pkg::*;
#(
    parameter int DOWN_MAX_CYCLES = DOWN_MAX_CYC,
    parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins and analog indications
    input wire logic ctrl_line,
    input wire logic fb_below_ref,
    input wire logic peak_current_hit,
    input wire logic undervoltage_lockout,
    input wire logic over_temperature,
    // Power stage control
    output logic input_switch,
    output logic main_switch,
    output logic [CODE_W-1:0] dac_code,
    output logic [1:0] current_limit_sel,
    output logic device_on,
    // AXI4-Lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Elaboration checks on the shortened counts
    if (SHUTDOWN_CYCLES <= DOWN_MAX_CYCLES || DOWN_MAX_CYCLES < DOWN_MIN_CYC) begin : g_chk
        $error("Shutdown count must exceed step-down window");
    end
    if (SHUTDOWN_CYCLES >= 65535) begin : g_chk_w
        $error("Shutdown count too wide for counter");
    end

    localparam int NSYNC = 5;
    localparam logic [15:0] UP_MIN_C = 16'(UP_MIN_CYC);
    localparam logic [15:0] UP_MAX_C = 16'(UP_MAX_CYC);
    localparam logic [15:0] DN_MIN_C = 16'(DOWN_MIN_CYC);
    localparam logic [15:0] DN_MAX_C = 16'(DOWN_MAX_CYCLES);
    localparam logic [15:0] OFF_C = 16'(SHUTDOWN_CYCLES);
    localparam logic [7:0] MAX_ON_C = 8'(MAX_ON_CYC - 1);
    localparam logic [7:0] MIN_OFF_C = 8'(MIN_OFF_CYC - 1);
    localparam logic [7:0] SS_LAST = 8'(SS_CYCLES - 1);

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] filt_reg;
    logic ctrl_f, fb_f, peak_f, undervoltage_lockout_f, ot_f;
    logic ctrl_prev_reg;
    logic ctrl_rise;
    logic [15:0] low_cnt_reg;
    bpc_dev_t dev_reg;
    bpc_sw_t sw_reg;
    logic [7:0] sw_cnt_reg;
    logic [7:0] ss_cnt_reg;
    logic fault;
    logic enable_evt;
    logic long_low;
    logic run;
    logic turn_on;
    logic [CODE_W-1:0] code_reg;
    logic [1:0] limit_reg;
    logic main_reg;
    logic in_sw_reg;
    logic on_reg;
    logic [31:0] control_reg;
    logic aw_held_reg, w_held_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] status_word;
    logic do_write;

    assign raw_in = {over_temperature, undervoltage_lockout, peak_current_hit,
                     fb_below_ref, ctrl_line};

    // Three-stage synchronisers; a change counts once stages two and three agree
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        logic [2:0] sh_reg;
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                sh_reg <= 3'h0;
            end
            else
            begin
                sh_reg <= {sh_reg[1:0], raw_in[i]};
            end
        end
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                filt_reg[i] <= 1'b0;
            end
            else if (sh_reg[1] == sh_reg[2])
            begin
                filt_reg[i] <= sh_reg[2];
            end
        end
    end

    assign {ot_f, undervoltage_lockout_f, peak_f, fb_f, ctrl_f} = filt_reg;

    // Event decode
    assign ctrl_rise = ctrl_f & ~ctrl_prev_reg;
    assign fault = undervoltage_lockout_f | ot_f | control_reg[CTL_SHUTDOWN_BIT]; // [RULE_13] [RULE_14]
    assign long_low = ~ctrl_f & (low_cnt_reg >= OFF_C); // [RULE_02]
    assign enable_evt = (dev_reg == DEV_OFF) & ctrl_rise & ~fault; // [RULE_03]
    assign run = (dev_reg == DEV_RUN) & ~fault;
    assign turn_on = run & (sw_reg == SW_WAIT) & fb_f; // [RULE_09] [RULE_12]

    // Previous control level for edge detection
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_prev_reg <= 1'b0;
        end
        else
        begin
            ctrl_prev_reg <= ctrl_f;
        end
    end

    // Length of the current low interval, saturating
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_cnt_reg <= 16'h0000;
        end
        else if (ctrl_f)
        begin
            low_cnt_reg <= 16'h0000;
        end
        else if (low_cnt_reg != 16'hFFFF)
        begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end
    end

    // Device on/off state
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dev_reg <= DEV_OFF;
        end
        else
        begin
            case (dev_reg)
                DEV_OFF: if (enable_evt) dev_reg <= DEV_RUN; // [RULE_03]
                DEV_RUN: if (fault || long_low) dev_reg <= DEV_OFF; // [RULE_02] [RULE_13]
                default: dev_reg <= DEV_OFF;
            endcase
        end
    end

    // Level code: center on start-up, steps decoded on each return to high
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_reg <= CODE_CENTER;
        end
        else if (enable_evt)
        begin
            code_reg <= CODE_CENTER; // [RULE_04]
        end
        else if (run && ctrl_rise)
        begin
            if (low_cnt_reg >= UP_MIN_C && low_cnt_reg <= UP_MAX_C && code_reg != CODE_MAX)
            begin
                code_reg <= code_reg + 6'h01; // [RULE_01] [RULE_15] [RULE_05]
            end
            else if (low_cnt_reg >= DN_MIN_C && low_cnt_reg <= DN_MAX_C
                     && code_reg != CODE_MIN)
            begin
                code_reg <= code_reg - 6'h01; // [RULE_01] [RULE_15] [RULE_06]
            end
        end
    end

    // Softstart: count switch cycles at quarter, then half limit
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            limit_reg <= LIMIT_QUARTER;
            ss_cnt_reg <= 8'h00;
        end
        else if (enable_evt)
        begin
            limit_reg <= LIMIT_QUARTER; // [RULE_03] [RULE_07]
            ss_cnt_reg <= 8'h00;
        end
        else if (turn_on && limit_reg != LIMIT_FULL)
        begin
            ss_cnt_reg <= ss_cnt_reg + 8'h01; // Wraps after 256 cycles
            if (ss_cnt_reg == SS_LAST)
            begin
                limit_reg <= (limit_reg == LIMIT_QUARTER) ? LIMIT_HALF : LIMIT_FULL; // [RULE_07]
            end
        end
    end

    // PFM switch timer
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_reg <= SW_WAIT;
            sw_cnt_reg <= 8'h00;
            main_reg <= 1'b0;
        end
        else if (!run)
        begin
            sw_reg <= SW_WAIT;
            sw_cnt_reg <= 8'h00;
            main_reg <= 1'b0; // [RULE_13] [RULE_14]
        end
        else
        begin
            case (sw_reg)
                SW_WAIT:
                begin
                    if (turn_on)
                    begin
                        sw_reg <= SW_ON;
                        sw_cnt_reg <= 8'h00;
                        main_reg <= 1'b1; // [RULE_09]
                    end
                end
                SW_ON:
                begin
                    if (peak_f || sw_cnt_reg == MAX_ON_C)
                    begin
                        sw_reg <= SW_REST; // [RULE_10] [RULE_11]
                        sw_cnt_reg <= 8'h00;
                        main_reg <= 1'b0;
                    end
                    else
                    begin
                        sw_cnt_reg <= sw_cnt_reg + 8'h01;
                    end
                end
                SW_REST:
                begin
                    if (sw_cnt_reg >= MIN_OFF_C)
                    begin
                        sw_reg <= SW_WAIT; // [RULE_12]
                    end
                    else
                    begin
                        sw_cnt_reg <= sw_cnt_reg + 8'h01;
                    end
                end
                default:
                begin
                    sw_reg <= SW_WAIT;
                    main_reg <= 1'b0;
                end
            endcase
        end
    end

    // Input switch and on flag follow the running state
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_sw_reg <= 1'b0;
            on_reg <= 1'b0;
        end
        else
        begin
            in_sw_reg <= run & ~long_low; // [RULE_08] [RULE_13] [RULE_14]
            on_reg <= run & ~long_low;
        end
    end

    assign input_switch = in_sw_reg;
    assign main_switch = main_reg;
    assign dac_code = code_reg;
    assign current_limit_sel = limit_reg;
    assign device_on = on_reg;

    // AXI write: address and data taken in either order
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
        end
        else
        begin
            awready_reg <= ~aw_held_reg & ~(s_axi_awvalid & awready_reg);
            wready_reg <= ~w_held_reg & ~(s_axi_wvalid & wready_reg);
            if (s_axi_awvalid && awready_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response and control register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            control_reg <= CONTROL_RESET;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (aw_addr_reg[3:2] <= ADDR_LEVEL[3:2]) ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr_reg[3:2] == ADDR_CONTROL[3:2] && w_strb_reg[0])
            begin
                control_reg[7:0] <= {7'h00, w_data_reg[CTL_SHUTDOWN_BIT]};
            end
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // Status word shows live state
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_ON_BIT] = on_reg;
        status_word[ST_IN_SW_BIT] = in_sw_reg;
        status_word[ST_MAIN_SW_BIT] = main_reg;
        status_word[ST_LIMIT_LSB +: 2] = limit_reg;
        status_word[ST_UNDERVOLTAGE_LOCKOUT_BIT] = undervoltage_lockout_f;
        status_word[ST_OT_BIT] = ot_f;
        status_word[ST_CTRL_BIT] = ctrl_f;
    end

    // AXI read channel
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            case (s_axi_araddr[3:2])
                ADDR_CONTROL[3:2]: rdata_reg <= control_reg;
                ADDR_STATUS[3:2]: rdata_reg <= status_word;
                ADDR_LEVEL[3:2]: rdata_reg <= {26'h0000000, code_reg};
                default:
                begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_reg)
        begin
            if (s_axi_rready)
            begin
                rvalid_reg <= 1'b0;
            end
        end
        else
        begin
            arready_reg <= 1'b1;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule // bpc_top
`default_nettype wire

// file: bpc_pkg.sv
/*
 * Constants shared by the boost converter control core: timing, codes, register map.
 * Assumes a single 25 MHz clock.
 */
// What this block does
// RULE_01: Low pulse 1-60 us steps code up, 140-240 us down, decoded on rise.
// RULE_02: Low interval of 560 us or more shuts the converter down.
// RULE_03: Rising control edge while off enables, always starting with softstart.
// RULE_04: Every start-up loads the center code 32 before any step.
// RULE_05: Level is a 6-bit code, 64 levels, code zero first.
// RULE_06: Code zero gives highest output, top code gives lowest output.
// RULE_07: Softstart: quarter limit 256 cycles, half limit 256 cycles, then full.
// RULE_08: While shut down the input switch stays open.
// RULE_09: Main switch turns on when feedback is below reference and off-time is met.
// RULE_10: Main switch turns off when peak current is reached.
// RULE_11: Main switch is forced off after the maximum on-time.
// RULE_12: After turn-off, switch stays off for minimum off-time and until feedback low.
// RULE_13: Undervoltage lockout keeps device off with both switches open.
// RULE_14: Over-temperature forces thermal shutdown with both switches open.
// RULE_15: Code saturates at 0 and 63; steps beyond are ignored.
// RULE_16: Host keeps the line high at least 1 us between step pulses.
package bpc_pkg;
    // Clock
    localparam int CLK_MHZ = 25;
    // Times in nanoseconds as printed
    localparam int UP_MIN_NS = 1000;
    localparam int UP_MAX_NS = 60000;
    localparam int DOWN_MIN_NS = 140000;
    localparam int DOWN_MAX_NS = 240000;
    localparam int SHUTDOWN_NS = 560000;
    localparam int MAX_ON_NS = 6000;
    localparam int MIN_OFF_NS = 400;
    // Cycle counts: least times round up, longest times round down
    localparam int UP_MIN_CYC = (UP_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int UP_MAX_CYC = (UP_MAX_NS * CLK_MHZ) / 1000;
    localparam int DOWN_MIN_CYC = (DOWN_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int DOWN_MAX_CYC = (DOWN_MAX_NS * CLK_MHZ) / 1000;
    localparam int SHUTDOWN_CYC = (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / 1000;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
    // Code and softstart
    localparam int CODE_W = 6;
    localparam logic [5:0] CODE_CENTER = 6'h20;
    localparam logic [5:0] CODE_MAX = 6'h3F;
    localparam logic [5:0] CODE_MIN = 6'h00;
    localparam int SS_CYCLES = 256;
    localparam logic [1:0] LIMIT_QUARTER = 2'h0;
    localparam logic [1:0] LIMIT_HALF = 2'h1;
    localparam logic [1:0] LIMIT_FULL = 2'h2;
    // Register map (byte addresses)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_LEVEL = 4'h8;
    localparam int CTL_SHUTDOWN_BIT = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam int ST_ON_BIT = 0;
    localparam int ST_IN_SW_BIT = 1;
    localparam int ST_MAIN_SW_BIT = 2;
    localparam int ST_LIMIT_LSB = 3;
    localparam int ST_UNDERVOLTAGE_LOCKOUT_BIT = 5;
    localparam int ST_OT_BIT = 6;
    localparam int ST_CTRL_BIT = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // States
    typedef enum logic {DEV_OFF, DEV_RUN} bpc_dev_t;
    typedef enum logic [1:0] {SW_WAIT, SW_ON, SW_REST} bpc_sw_t;
endpackage

// file: bpc_chk.sv
/*
 * Pin-level checks of the converter control core.
 * Assumes binding into bpc_top, one clock, rst_n active low.
 */
`timescale 1ns/1ps
`default_nettype none
module bpc_chk
    import bpc_pkg::*;
#(
    parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin and analog indications
    input wire logic ctrl_line,
    input wire logic peak_current_hit,
    input wire logic undervoltage_lockout,
    input wire logic over_temperature,
    // Power stage outputs
    input wire logic input_switch,
    input wire logic main_switch,
    input wire logic [CODE_W-1:0] dac_code,
    input wire logic [1:0] current_limit_sel,
    input wire logic device_on
);
    int on_cnt, off_cnt, low_cnt;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Run lengths of switch on, switch off and control line low
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            on_cnt <= 0;
            off_cnt <= 1000;
            low_cnt <= 0;
        end
        else
        begin
            on_cnt <= main_switch ? on_cnt + 1 : 0;
            off_cnt <= main_switch ? 0 : ((off_cnt < 1000) ? off_cnt + 1 : off_cnt);
            low_cnt <= ctrl_line ? 0 : ((low_cnt < 100000) ? low_cnt + 1 : low_cnt);
        end
    end
    chk_off_switches: assert property (!device_on [*3] |-> !input_switch && !main_switch)
        else $error("switch closed while off");
    chk_undervoltage_lockout_off: assert property (undervoltage_lockout [*7] |->
        !device_on && !input_switch && !main_switch) else $error("running in lockout");
    chk_ot_off: assert property (over_temperature [*7] |->
        !device_on && !input_switch && !main_switch) else $error("running while hot");
    chk_max_on: assert property (on_cnt <= MAX_ON_CYC)
        else $error("main switch on too long");
    chk_min_off: assert property ($rose(main_switch) |-> off_cnt >= MIN_OFF_CYC)
        else $error("off time too short");
    chk_on_running: assert property ($rose(main_switch) |-> device_on)
        else $error("switching while off");
    chk_peak_off: assert property (main_switch ##1 peak_current_hit [*7] |-> !main_switch)
        else $error("no turn-off at peak");
    chk_start_state: assert property ($rose(device_on) |->
        dac_code == CODE_CENTER && current_limit_sel == LIMIT_QUARTER)
        else $error("bad start state");
    chk_code_step: assert property (device_on && $past(device_on) && dac_code != $past(dac_code)
        |-> dac_code == $past(dac_code) + 6'h01 || dac_code == $past(dac_code) - 6'h01)
        else $error("code moved more than one");
    chk_code_sat: assert property (device_on && $past(device_on) |->
        !(($past(dac_code) == CODE_MAX && dac_code == CODE_MIN)
        || ($past(dac_code) == CODE_MIN && dac_code == CODE_MAX))) else $error("code wrapped");
    chk_limit_order: assert property (device_on && $past(device_on)
        && current_limit_sel != $past(current_limit_sel)
        |-> current_limit_sel == $past(current_limit_sel) + 2'h1) else $error("limit out of order");
    chk_long_low: assert property (low_cnt >= SHUTDOWN_CYCLES + 8 |-> !device_on)
        else $error("no shutdown on long low");
endmodule // bpc_chk
bind bpc_top bpc_chk #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) u_chk (.*);
`default_nettype wire

// file: bpc_host.sv
/*
 * Host model driving the single control line with timed low intervals.
 * Assumes the caller's clock is the core's 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bpc_host (
    // Clock
    input wire logic clock,
    // Control line toward the device
    output logic ctrl_line
);
    // Line starts low so the first release is an enabling rise
    initial ctrl_line = 1'b0;
    // Drive one level for a number of cycles
    task automatic hold(input logic v, input int n);
        @(posedge clock);
        ctrl_line <= v;
        repeat (n) @(posedge clock);
    endtask
    // Timed low interval, then the high gap between steps
    task automatic low_pulse(input int n);
        hold(1'b0, n);
        hold(1'b1, 40);
    endtask
endmodule // bpc_host
`default_nettype wire

// file: testbench.sv
/*
 * Self-checking bench for the converter control core.
 * Assumes bpc_host on the control line and shortened step-down and shutdown counts.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bpc_pkg::*;
    localparam int DOWN_T = 4000;
    localparam int SHUT_T = 4500;
    logic clock = 1'b0, rst_n = 1'b0, fb_below_ref = 1'b0, peak_current_hit = 1'b0;
    logic undervoltage_lockout = 1'b0, over_temperature = 1'b0, pk_en = 1'b0, pk_hold = 1'b0;
    wire ctrl_line;
    logic input_switch, main_switch, device_on, main_q = 1'b0;
    logic [CODE_W-1:0] dac_code, exp_code;
    logic [1:0] current_limit_sel, lim_q = 2'h0, resp, s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int error_cnt = 0, samples_checked = 0, seed = 4, nq = 0, nh = 0, on_run = 0, last_on = 0;
    int len, i, k;
    int corner[5] = '{UP_MAX_CYC - 5, DOWN_MIN_CYC + 5, 2500, 4250, DOWN_T - 5};
    bpc_host u_host (.clock(clock), .ctrl_line(ctrl_line));
    // Every port of the core meets the bench signal of the same name
    bpc_top #(.DOWN_MAX_CYCLES(DOWN_T), .SHUTDOWN_CYCLES(SHUT_T)) u_dut (.*);
    // Clock
    initial forever #20 clock = ~clock;
    // Inductor stand-in plus turn-on and on-time bookkeeping
    always @(posedge clock)
    begin
        peak_current_hit <= pk_hold | (pk_en & main_switch);
        main_q <= main_switch;
        lim_q <= current_limit_sel;
        if (main_switch && !main_q && lim_q == LIMIT_QUARTER) nq <= nq + 1;
        if (main_switch && !main_q && lim_q == LIMIT_HALF) nh <= nh + 1;
        if (main_switch) on_run <= on_run + 1;
        else if (on_run > 0) last_on <= on_run;
        if (!main_switch) on_run <= 0;
    end
    task automatic summarize();
        if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask
    task automatic fail(input string what);
        $display("MISMATCH %s expected done seen timeout", what);
        error_cnt++;
        summarize();
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (n > 100) fail("bvalid");
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (n > 100) fail("rvalid");
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_on(input logic v);
        int n;
        n = 0;
        while (device_on !== v)
        begin
            @(posedge clock);
            n++;
            if (n > 200) fail("device_on");
        end
    endtask
    // Expected code after one low interval of len cycles
    function automatic logic [CODE_W-1:0] next_code(input logic [CODE_W-1:0] c, input int len);
        if (len >= UP_MIN_CYC && len <= UP_MAX_CYC) return (c == CODE_MAX) ? c : c + 6'h01;
        if (len >= DOWN_MIN_CYC && len <= DOWN_T) return (c == CODE_MIN) ? c : c - 6'h01;
        return c;
    endfunction
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        chk("dac_code", CODE_CENTER, dac_code);
        chk("input_switch", 1'b0, input_switch);
        axi_rd(4'hC, rd, resp);
        chk("rresp", RESP_SLVERR, resp);
        chk("rdata", 32'h0, rd);
        axi_wr(ADDR_LEVEL, 32'h0000_0005, resp);
        chk("bresp", RESP_OKAY, resp);
        fb_below_ref <= 1'b1;
        pk_en <= 1'b1;
        u_host.hold(1'b1, 40);
        wait_on(1'b1);
        axi_rd(ADDR_STATUS, rd, resp);
        chk("status_on", 1'b1, rd[ST_ON_BIT]);
        i = 0;
        while (current_limit_sel !== LIMIT_FULL)
        begin
            @(posedge clock);
            i++;
            if (i > 40000) fail("softstart");
        end
        repeat (2) @(posedge clock);
        chk("quarter_turn_ons", SS_CYCLES, nq);
        chk("half_turn_ons", SS_CYCLES, nh);
        pk_en <= 1'b0;
        repeat (400) @(posedge clock);
        chk("on_time", MAX_ON_CYC, last_on);
        pk_hold <= 1'b1;
        repeat (60) @(posedge clock);
        pk_hold <= 1'b0;
        pk_en <= 1'b1;
        fb_below_ref <= 1'b0;
        repeat (30) @(posedge clock);
        chk("main_switch", 1'b0, main_switch);
        fb_below_ref <= 1'b1;
        exp_code = CODE_CENTER;
        for (i = 0; i < 16; i++)
        begin
            if (i < 5) len = corner[i];
            else if ($random(seed) & 1) len = 30 + {$random(seed)} % 1400;
            else len = 3550 + {$random(seed)} % 400;
            u_host.low_pulse(len);
            exp_code = next_code(exp_code, len);
            chk("dac_code", exp_code, dac_code);
        end
        axi_rd(ADDR_LEVEL, rd, resp);
        chk("level", {26'h0, exp_code}, rd);
        for (i = 0; i < 45; i++) u_host.low_pulse(40);
        chk("dac_code", CODE_MAX, dac_code);
        for (k = 0; k < 3; k++)
        begin
            if (k == 0) undervoltage_lockout <= 1'b1;
            if (k == 1) over_temperature <= 1'b1;
            if (k == 2) axi_wr(ADDR_CONTROL, 32'h0000_0001, resp);
            repeat (10) @(posedge clock);
            chk("device_on", 1'b0, device_on);
            chk("input_switch", 1'b0, input_switch);
            chk("main_switch", 1'b0, main_switch);
            undervoltage_lockout <= 1'b0;
            over_temperature <= 1'b0;
            if (k == 2) axi_rd(ADDR_CONTROL, rd, resp);
            if (k == 2) chk("control", 32'h0000_0001, rd);
            if (k == 2) axi_wr(ADDR_CONTROL, 32'h0000_0000, resp);
            repeat (10) @(posedge clock);
            chk("device_on", 1'b0, device_on);
            u_host.low_pulse(30);
            wait_on(1'b1);
            chk("dac_code", CODE_CENTER, dac_code);
            chk("limit", LIMIT_QUARTER, current_limit_sel);
        end
        u_host.hold(1'b0, SHUT_T + 20);
        chk("device_on", 1'b0, device_on);
        chk("input_switch", 1'b0, input_switch);
        u_host.hold(1'b1, 40);
        chk("device_on", 1'b1, device_on);
        chk("dac_code", CODE_CENTER, dac_code);
        summarize();
    end
endmodule // testbench
`default_nettype wire
